//--- sadb_interconnect.sv
`timescale 1ns/100ps
module sadb_interconnect (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        boot_select_pin,
  input  wire logic        boot_option_bit,
  input  wire logic        remap_wr,
  input  wire logic [1:0]  remap_sel,
  input  wire logic        cpu_req,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        cpu_write,
  input  wire logic [1:0]  cpu_size,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_gnt,
  output logic             cpu_done,
  output logic [31:0]      cpu_rdata,
  output logic             cpu_err,
  output logic             cpu_hard_fault,
  input  wire logic        dma_req,
  input  wire logic [31:0] dma_addr,
  input  wire logic        dma_write,
  input  wire logic [1:0]  dma_size,
  input  wire logic [31:0] dma_wdata,
  output logic             dma_gnt,
  output logic             dma_done,
  output logic [31:0]      dma_rdata,
  output logic             dma_err,
  output logic [31:0]      mem_addr,
  output logic             mem_write,
  output logic [3:0]       mem_be,
  output logic [31:0]      mem_wdata,
  output logic             sram_req,
  input  wire logic [31:0] sram_rdata,
  input  wire logic        sram_ack,
  output logic             flash_req,
  input  wire logic [31:0] flash_rdata,
  input  wire logic        flash_ack,
  output logic             ahbp_req,
  input  wire logic [31:0] ahbp_rdata,
  input  wire logic        ahbp_ack,
  input  wire logic        ahbp_err,
  output logic             psel,
  output logic             penable,
  output logic [31:0]      paddr,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             boot_done,
  output sadb_pkg::sadb_boot_t boot_map
);

  typedef struct packed {
    sadb_pkg::sadb_state_t st;
    logic [2:0]            boot_cnt;
    sadb_pkg::sadb_boot_t  alias_sel;
    logic                  owner;
    logic                  last_owner;
    sadb_pkg::sadb_tgt_t   tgt;
    logic [31:0]           addr;
    logic                  write;
    logic [3:0]            be;
    logic [31:0]           wdata;
    logic [31:0]           rdata;
    logic                  err;
    logic                  cpu_done;
    logic                  dma_done;
    logic                  hard_fault;
    logic                  sram_req;
    logic                  flash_req;
    logic                  ahbp_req;
    logic                  psel;
    logic                  penable;
  } sadb_regs_t;

  localparam logic OWNER_CPU = 1'b0;
  localparam logic OWNER_DMA = 1'b1;

  sadb_regs_t regs_r;
  sadb_regs_t regs_nxt;

  // request selected for decode this cycle
  logic                 pick_valid;
  logic                 pick_owner;
  logic [31:0]          req_addr;
  logic                 req_write;
  logic [1:0]           req_size;
  logic [31:0]          req_wdata;

  // decode results
  logic [31:0]          phys;
  logic [3:0]           req_be;
  logic                 aligned;
  sadb_pkg::sadb_tgt_t  req_tgt;
  logic                 ahb_hit;
  logic                 ahb_size_ok;
  logic                 apb_hit;
  logic                 apb_size_ok;

  // slave answer for the transfer in flight
  logic                 slv_ack;
  logic [31:0]          slv_rdata;
  logic                 slv_err;

  // processor first after reset, since last_owner resets to dma
  always_comb begin
    pick_valid = cpu_req || dma_req;
    if (cpu_req && dma_req) begin
      pick_owner = (regs_r.last_owner == OWNER_CPU) ? OWNER_DMA : OWNER_CPU;
    end else begin
      pick_owner = cpu_req ? OWNER_CPU : OWNER_DMA;
    end
    req_addr  = (pick_owner == OWNER_CPU) ? cpu_addr  : dma_addr;
    req_write = (pick_owner == OWNER_CPU) ? cpu_write : dma_write;
    req_size  = (pick_owner == OWNER_CPU) ? cpu_size  : dma_size;
    req_wdata = (pick_owner == OWNER_CPU) ? cpu_wdata : dma_wdata;
  end

  always_comb begin
    req_be  = 4'h0;
    aligned = 1'b0;
    case (req_size)
      sadb_pkg::SZ_BYTE: begin
        req_be  = 4'(4'h1 << req_addr[1:0]);
        aligned = 1'b1;
      end
      sadb_pkg::SZ_HALF: begin
        req_be  = req_addr[1] ? 4'hc : 4'h3;
        aligned = ~req_addr[0];
      end
      sadb_pkg::SZ_WORD: begin
        req_be  = 4'hf;
        aligned = (req_addr[1:0] == 2'h0);
      end
      default: begin
        req_be  = 4'h0;
        aligned = 1'b0;
      end
    endcase
  end

  // alias window folds onto the native base of the boot memory
  always_comb begin
    phys = req_addr;
    if ((req_addr[sadb_pkg::REGION_MSB:sadb_pkg::REGION_LSB] == sadb_pkg::REGION_CODE)
        && (req_addr <= sadb_pkg::ALIAS_LAST)) begin
      case (regs_r.alias_sel)
        sadb_pkg::BOOT_FLASH:  phys = sadb_pkg::FLASH_BASE  | req_addr;
        sadb_pkg::BOOT_SYSMEM: phys = sadb_pkg::SYSMEM_BASE | req_addr;
        sadb_pkg::BOOT_SRAM:   phys = sadb_pkg::SRAM_BASE   | req_addr;
        default:               phys = sadb_pkg::FLASH_BASE  | req_addr;
      endcase
    end
  end

  // flash controller window sits in the ahb table
  sadb_win_match #(
    .NUM     (sadb_pkg::NUM_AHB_WIN)
  ) u_ahb_win (
    .addr    (phys),
    .size    (req_size),
    .win_lo  (sadb_pkg::AHB_LO),
    .win_hi  (sadb_pkg::AHB_HI),
    .win_cls (sadb_pkg::AHB_CLS),
    .hit     (ahb_hit),
    .size_ok (ahb_size_ok)
  );

  sadb_win_match #(
    .NUM     (sadb_pkg::NUM_APB_WIN)
  ) u_apb_win (
    .addr    (phys),
    .size    (req_size),
    .win_lo  (sadb_pkg::APB_LO),
    .win_hi  (sadb_pkg::APB_HI),
    .win_cls (sadb_pkg::APB_CLS),
    .hit     (apb_hit),
    .size_ok (apb_size_ok)
  );

  // region split on top three bits
  always_comb begin
    req_tgt = sadb_pkg::TGT_FAULT;
    case (phys[sadb_pkg::REGION_MSB:sadb_pkg::REGION_LSB])
      sadb_pkg::REGION_CODE: begin
        if ((phys >= sadb_pkg::FLASH_BASE) && (phys <= sadb_pkg::FLASH_LAST)) begin
          req_tgt = sadb_pkg::TGT_FLASH;
        // boot loader, id, option and factory areas
        end else if ((phys >= sadb_pkg::SYSMEM_BASE) && (phys <= sadb_pkg::INFO_LAST)) begin
          req_tgt = sadb_pkg::TGT_FLASH;
        end
      end
      sadb_pkg::REGION_SRAM: begin
        // past the implemented sram is a fault
        if (phys <= sadb_pkg::SRAM_LAST) begin
          req_tgt = sadb_pkg::TGT_SRAM;
        end
      end
      sadb_pkg::REGION_PERI, 3'h3: begin
        // apb below the ahb base, ahb and i/o ports above
        if ((phys >= sadb_pkg::APB_BASE) && (phys < sadb_pkg::AHB_BASE)) begin
          if (!apb_hit) begin
            req_tgt = sadb_pkg::TGT_QUIET;
          end else if (apb_size_ok) begin
            req_tgt = sadb_pkg::TGT_APB;
          end
        end else if ((phys >= sadb_pkg::AHB_BASE) && (phys <= sadb_pkg::IOP_LAST)) begin
          if (ahb_hit && ahb_size_ok) begin
            req_tgt = sadb_pkg::TGT_AHBP;
          end
        end
      end
      sadb_pkg::REGION_CORE: begin
        if (phys <= sadb_pkg::CORE_LAST) begin
          req_tgt = sadb_pkg::TGT_AHBP;
        end
      end
      default: req_tgt = sadb_pkg::TGT_FAULT;
    endcase
    // misaligned or illegal width never reaches a slave
    if (!aligned) begin
      req_tgt = sadb_pkg::TGT_FAULT;
    end
  end

  always_comb begin
    slv_ack   = 1'b0;
    slv_rdata = 32'h0000_0000;
    slv_err   = 1'b0;
    case (regs_r.tgt)
      sadb_pkg::TGT_SRAM: begin
        slv_ack   = sram_ack;
        slv_rdata = sram_rdata;
      end
      sadb_pkg::TGT_FLASH: begin
        slv_ack   = flash_ack;
        slv_rdata = flash_rdata;
      end
      sadb_pkg::TGT_AHBP: begin
        slv_ack   = ahbp_ack;
        slv_rdata = ahbp_rdata;
        slv_err   = ahbp_err;
      end
      default: begin
        slv_ack   = 1'b0;
        slv_rdata = 32'h0000_0000;
        slv_err   = 1'b0;
      end
    endcase
  end

  always_comb begin
    regs_nxt            = regs_r;
    regs_nxt.cpu_done   = 1'b0;
    regs_nxt.dma_done   = 1'b0;
    regs_nxt.hard_fault = 1'b0;
    // remap select overrides the alias once boot is latched
    if (remap_wr && (regs_r.st != sadb_pkg::ST_BOOT)) begin
      case (remap_sel)
        sadb_pkg::REMAP_SYSMEM: regs_nxt.alias_sel = sadb_pkg::BOOT_SYSMEM;
        sadb_pkg::REMAP_SRAM:   regs_nxt.alias_sel = sadb_pkg::BOOT_SRAM;
        default:                regs_nxt.alias_sel = sadb_pkg::BOOT_FLASH;
      endcase
    end
    case (regs_r.st)
      sadb_pkg::ST_BOOT: begin
        // sample on the fourth edge after release
        if (regs_r.boot_cnt == sadb_pkg::BOOT_CNT_LAST) begin
          // boot pin and option bit pick the boot memory
          if (!boot_select_pin) begin
            regs_nxt.alias_sel = sadb_pkg::BOOT_FLASH;
          end else if (boot_option_bit) begin
            regs_nxt.alias_sel = sadb_pkg::BOOT_SYSMEM;
          end else begin
            regs_nxt.alias_sel = sadb_pkg::BOOT_SRAM;
          end
          regs_nxt.st = sadb_pkg::ST_IDLE;
        end else begin
          regs_nxt.boot_cnt = 3'(regs_r.boot_cnt + 3'h1);
        end
      end
      sadb_pkg::ST_IDLE: begin
        if (pick_valid) begin
          regs_nxt.owner = pick_owner;
          regs_nxt.tgt   = req_tgt;
          regs_nxt.addr  = phys;
          regs_nxt.write = req_write;
          regs_nxt.be    = req_be;
          regs_nxt.wdata = req_wdata;
          regs_nxt.rdata = 32'h0000_0000;
          case (req_tgt)
            sadb_pkg::TGT_SRAM: begin
              regs_nxt.sram_req = 1'b1;
              regs_nxt.st       = sadb_pkg::ST_MEM;
            end
            sadb_pkg::TGT_FLASH: begin
              regs_nxt.flash_req = 1'b1;
              regs_nxt.st        = sadb_pkg::ST_MEM;
            end
            sadb_pkg::TGT_AHBP: begin
              regs_nxt.ahbp_req = 1'b1;
              regs_nxt.st       = sadb_pkg::ST_MEM;
            end
            sadb_pkg::TGT_APB: begin
              regs_nxt.psel = 1'b1;
              regs_nxt.st   = sadb_pkg::ST_APB_EN;
            end
            sadb_pkg::TGT_QUIET: begin
              regs_nxt.err = 1'b0;
              regs_nxt.st  = sadb_pkg::ST_DONE;
            end
            default: begin
              regs_nxt.err = 1'b1;
              regs_nxt.st  = sadb_pkg::ST_DONE;
            end
          endcase
        end
      end
      sadb_pkg::ST_MEM: begin
        if (slv_ack) begin
          regs_nxt.rdata     = regs_r.write ? 32'h0000_0000 : slv_rdata;
          regs_nxt.err       = slv_err;
          regs_nxt.sram_req  = 1'b0;
          regs_nxt.flash_req = 1'b0;
          regs_nxt.ahbp_req  = 1'b0;
          regs_nxt.st        = sadb_pkg::ST_DONE;
        end
      end
      sadb_pkg::ST_APB_EN: begin
        // access phase held until the peripheral is ready
        regs_nxt.penable = 1'b1;
        if (regs_r.penable && pready) begin
          regs_nxt.rdata   = regs_r.write ? 32'h0000_0000 : prdata;
          regs_nxt.err     = pslverr;
          regs_nxt.psel    = 1'b0;
          regs_nxt.penable = 1'b0;
          regs_nxt.st      = sadb_pkg::ST_DONE;
        end
      end
      sadb_pkg::ST_DONE: begin
        regs_nxt.st = sadb_pkg::ST_IDLE;
      end
      default: regs_nxt.st = sadb_pkg::ST_IDLE;
    endcase
    // ownership changes only once the transfer is answered
    if ((regs_nxt.st == sadb_pkg::ST_DONE) && (regs_r.st != sadb_pkg::ST_DONE)) begin
      regs_nxt.last_owner = regs_nxt.owner;
      regs_nxt.cpu_done   = (regs_nxt.owner == OWNER_CPU);
      regs_nxt.dma_done   = (regs_nxt.owner == OWNER_DMA);
      // error seen by the processor becomes a hard fault
      regs_nxt.hard_fault = (regs_nxt.owner == OWNER_CPU) && regs_nxt.err;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regs_r            <= '0;
      regs_r.st         <= sadb_pkg::ST_BOOT;
      regs_r.alias_sel  <= sadb_pkg::BOOT_FLASH;
      regs_r.tgt        <= sadb_pkg::TGT_FAULT;
      regs_r.last_owner <= OWNER_DMA;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // grants held off until the boot latch is taken
  assign cpu_gnt        = (regs_r.st == sadb_pkg::ST_IDLE) && pick_valid &&
                          (pick_owner == OWNER_CPU);
  assign dma_gnt        = (regs_r.st == sadb_pkg::ST_IDLE) && pick_valid &&
                          (pick_owner == OWNER_DMA);
  assign cpu_done       = regs_r.cpu_done;
  assign cpu_rdata      = regs_r.rdata;
  assign cpu_err        = regs_r.err;
  assign cpu_hard_fault = regs_r.hard_fault;
  assign dma_done       = regs_r.dma_done;
  assign dma_rdata      = regs_r.rdata;
  assign dma_err        = regs_r.err;
  assign mem_addr       = regs_r.addr;
  assign mem_write      = regs_r.write;
  assign mem_be         = regs_r.be;
  assign mem_wdata      = regs_r.wdata;
  assign sram_req       = regs_r.sram_req;
  assign flash_req      = regs_r.flash_req;
  assign ahbp_req       = regs_r.ahbp_req;
  assign psel           = regs_r.psel;
  assign penable        = regs_r.penable;
  assign paddr          = regs_r.addr;
  assign pwrite         = regs_r.write;
  assign pwdata         = regs_r.wdata;
  // reads carry no strobes on apb
  assign pstrb          = regs_r.write ? regs_r.be : 4'h0;
  assign boot_done      = (regs_r.st != sadb_pkg::ST_BOOT);
  assign boot_map       = regs_r.alias_sel;

endmodule

//--- sadb_interconnect_tb_top.sv
`timescale 1ns/100ps
module sadb_interconnect_tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, pin = 1'b0, opt = 1'b0, remap_wr = 1'b0;
  logic [1:0] remap_sel = 2'h0, stall = 2'h0, req = 2'h0, wr = 2'h0, gnt, done;
  logic [31:0] addr [2] = '{default: 32'h0};
  logic [31:0] wdata [2] = '{default: 32'h0};
  logic [1:0] size [2] = '{default: 2'h0};
  logic [31:0] cpu_rdata, dma_rdata, mem_addr, mem_wdata, pwdata, rd, w, apb_v;
  logic cpu_err, dma_err, cpu_hard_fault, mem_write, sram_req, flash_req, ahbp_req, pwrite;
  logic sram_ack, flash_ack, ahbp_ack, psel, penable, pready, boot_done;
  logic [3:0] mem_be;
  logic [15:0] lfsr_r = 16'h0046;
  logic [32:0] cq [$], dq [$], ce;
  sadb_pkg::sadb_boot_t boot_map;
  int num_errors = 0, cmp_count = 0;
  localparam logic [31:0] TA [16] = '{32'h2000_2000, 32'h0801_0000, 32'h4000_0000,
    32'h1fff_0f80, 32'h2000_0000, 32'h1fff_0e00, 32'h4002_1064, 32'h4000_7000, 32'h4000_7002,
    32'h4002_1800, 32'h4002_2120, 32'h4002_2124, 32'he000_0000, 32'h5000_0400, 32'h0800_fffc,
    32'h2000_0001};
  // size, error, zero data
  localparam logic [3:0] TS [16] = '{4'ha, 4'ha, 4'h9, 4'ha, 4'he, 4'h8, 4'ha, 4'h2, 4'h4,
    4'h0, 4'h8, 4'ha, 4'h8, 4'h8, 4'h8, 4'h6};
  always #25 core_clk = ~core_clk;
  sadb_interconnect dut_u (.core_clk, .rst_n, .boot_select_pin(pin), .boot_option_bit(opt),
    .remap_wr, .remap_sel, .cpu_req(req[0]), .cpu_addr(addr[0]), .cpu_write(wr[0]),
    .cpu_size(size[0]), .cpu_wdata(wdata[0]), .cpu_gnt(gnt[0]), .cpu_done(done[0]),
    .cpu_rdata, .cpu_err, .cpu_hard_fault, .dma_req(req[1]), .dma_addr(addr[1]),
    .dma_write(wr[1]), .dma_size(size[1]), .dma_wdata(wdata[1]), .dma_gnt(gnt[1]),
    .dma_done(done[1]), .dma_rdata, .dma_err, .mem_addr, .mem_write, .mem_be, .mem_wdata,
    .sram_req, .sram_rdata(rd), .sram_ack, .flash_req, .flash_rdata(rd), .flash_ack,
    .ahbp_req, .ahbp_rdata(rd), .ahbp_ack, .ahbp_err(1'b0), .psel, .penable, .paddr(),
    .pwrite, .pwdata, .pstrb(), .prdata(rd), .pready, .pslverr(1'b0), .boot_done, .boot_map);
  sadb_slave_model far_u (.core_clk, .rst_n, .stall, .mem_addr, .mem_write, .mem_be,
    .mem_wdata, .sram_req, .flash_req, .ahbp_req, .psel, .penable, .pwrite, .pwdata,
    .rdata(rd), .sram_ack, .flash_ack, .ahbp_ack, .pready);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] pv(input logic [31:0] a);
    if (a[31:28] == 4'h4 && a < 32'h4002_0000) return apb_v;
    return (a >= 32'h4002_0000) ? {a[15:0], a[31:16]} : ~a;
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input int m, input logic [31:0] a, input logic wv, input logic [1:0] s,
                      input logic [31:0] d, input logic [32:0] e);
    int n;
    if (m == 0) cq.push_back(e);
    else dq.push_back(e);
    @(posedge core_clk);
    req[m] <= 1'b1;
    addr[m] <= a;
    wr[m] <= wv;
    size[m] <= s;
    wdata[m] <= d;
    for (n = 0; n < 40 && done[m] !== 1'b1; n++) @(posedge core_clk);
    req[m] <= 1'b0;
    if (n == 40) begin
      num_errors++;
      print_verdict();
    end
  endtask
  // oldest note per completion
  always @(posedge core_clk) begin
    if (done[0] === 1'b1) begin
      ce = cq.pop_front();
      chk("cpu result", {cpu_err, cpu_rdata}, ce);
      chk("cpu hard fault", {32'h0, cpu_hard_fault}, {32'h0, ce[32]});
    end
    if (done[1] === 1'b1) chk("dma result", {dma_err, dma_rdata}, dq.pop_front());
  end
  initial begin
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      rst_n <= 1'b0;
      pin <= (i == 0);
      opt <= (i != 1);
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      if (i == 2) fork
        xfer(0, 32'h0, 1'b0, 2'h3, 32'h0, {1'b1, 32'h0});
      join_none
      repeat (3) @(posedge core_clk);
      pin <= ~pin;
      opt <= ~opt;
      @(posedge core_clk);
      pin <= ~pin;
      opt <= ~opt;
      repeat (4) @(posedge core_clk);
      chk("boot map", {31'h0, boot_map}, 33'(i));
    end
    $display("boot selection done");
    for (int k = 0; k < 4; k++) begin
      w = {lfsr_r, ~lfsr_r};
      lfsr_r = lfsr(lfsr_r);
      stall <= lfsr_r[1:0];
      fork
        xfer(0, 32'h2000_0100 + 32'(8 * k), 1'b1, sadb_pkg::SZ_WORD, w, 33'h0);
        xfer(1, 32'h2000_0104 + 32'(8 * k), 1'b1, sadb_pkg::SZ_WORD, ~w, 33'h0);
      join
      fork
        xfer(0, 32'h2000_0104 + 32'(8 * k), 1'b0, sadb_pkg::SZ_WORD, 32'h0, {1'b0, ~w});
        xfer(1, 32'h2000_0100 + 32'(8 * k), 1'b0, sadb_pkg::SZ_WORD, 32'h0, {1'b0, w});
      join
    end
    $display("arbitration done");
    xfer(0, 32'h2000_0010, 1'b1, sadb_pkg::SZ_WORD, w, 33'h0);
    xfer(0, 32'h2000_0012, 1'b1, sadb_pkg::SZ_BYTE, {8'h0, lfsr_r[7:0], 16'h0}, 33'h0);
    w = {w[31:24], lfsr_r[7:0], w[15:0]};
    xfer(0, 32'h2000_0012, 1'b0, sadb_pkg::SZ_HALF, 32'h0, {1'b0, w});
    for (int j = 0; j < 4; j++) begin
      @(posedge core_clk);
      remap_sel <= 2'(j);
      remap_wr <= 1'b1;
      @(posedge core_clk);
      remap_wr <= 1'b0;
      xfer(0, 32'h0000_0010, 1'b0, sadb_pkg::SZ_WORD, 32'h0, {1'b0, (j == 3) ? w :
        ~((j == 1) ? sadb_pkg::SYSMEM_BASE + 32'h10 : sadb_pkg::FLASH_BASE + 32'h10)});
      chk("remap", {31'h0, boot_map}, (j == 3) ? 33'h2 : 33'(j == 1));
    end
    $display("alias and remap done");
    apb_v = w;
    xfer(1, 32'h4000_2800, 1'b1, sadb_pkg::SZ_WORD, w, 33'h0);
    for (int k = 0; k < 16; k++) begin
      xfer(k % 2, TA[k], k > 13, TS[k][3:2], ~w, {TS[k][1], (TS[k][1] | TS[k][0] | k > 13) ?
        32'h0 : pv(TA[k])});
      xfer(k % 2, TA[k], 1'b0, TS[k][3:2], 32'h0, {TS[k][1], (|TS[k][1:0]) ? 32'h0 : pv(TA[k])});
    end
    $display("decode table done");
    repeat (4) @(posedge core_clk);
    print_verdict();
  end
endmodule

//--- sadb_pkg.sv
package sadb_pkg;

  // transfer sizes as presented by the masters
  localparam logic [1:0]  SZ_BYTE = 2'h0;
  localparam logic [1:0]  SZ_HALF = 2'h1;
  localparam logic [1:0]  SZ_WORD = 2'h2;

  // window size classes
  localparam logic [1:0]  CLS_WORD = 2'h0;
  localparam logic [1:0]  CLS_HALF = 2'h1;
  localparam logic [1:0]  CLS_ANY  = 2'h2;

  // eight 512 Mbyte regions, picked by the top three address bits
  localparam int          REGION_MSB  = 31;
  localparam int          REGION_LSB  = 29;
  localparam logic [2:0]  REGION_CODE = 3'h0;
  localparam logic [2:0]  REGION_SRAM = 3'h1;
  localparam logic [2:0]  REGION_PERI = 3'h2;
  localparam logic [2:0]  REGION_CORE = 3'h7;

  localparam logic [31:0] ALIAS_LAST  = 32'h0000_ffff;
  localparam logic [31:0] FLASH_BASE  = 32'h0800_0000;
  localparam logic [31:0] FLASH_LAST  = 32'h0800_ffff;
  localparam logic [31:0] SYSMEM_BASE = 32'h1fff_0000;
  localparam logic [31:0] INFO_LAST   = 32'h1fff_0f7f;
  localparam logic [31:0] SRAM_BASE   = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST   = 32'h2000_1fff;
  localparam logic [31:0] APB_BASE    = 32'h4000_0000;
  localparam logic [31:0] AHB_BASE    = 32'h4002_0000;
  localparam logic [31:0] IOP_LAST    = 32'h5fff_ffff;
  localparam logic [31:0] CORE_BASE   = 32'he000_0000;
  localparam logic [31:0] CORE_LAST   = 32'he00f_ffff;

  // peripheral windows on the AHB side, I/O ports included
  localparam int NUM_AHB_WIN = 8;
  localparam logic [NUM_AHB_WIN-1:0][31:0] AHB_LO = {
    32'h4002_0000, 32'h4002_1000, 32'h4002_1800, 32'h4002_2000,
    32'h4002_3000, 32'h5000_0000, 32'h5000_0400, 32'h5000_1400};
  localparam logic [NUM_AHB_WIN-1:0][31:0] AHB_HI = {
    32'h4002_003c, 32'h4002_1060, 32'h4002_1884, 32'h4002_2120,
    32'h4002_3008, 32'h5000_03ff, 32'h5000_07ff, 32'h5000_17ff};
  localparam logic [NUM_AHB_WIN-1:0][1:0] AHB_CLS = {
    CLS_WORD, CLS_ANY, CLS_ANY, CLS_WORD, CLS_WORD, CLS_ANY, CLS_ANY, CLS_ANY};

  // peripheral windows behind the bridge
  localparam int NUM_APB_WIN = 20;
  localparam logic [NUM_APB_WIN-1:0][31:0] APB_LO = {
    32'h4001_5800, 32'h4001_4800, 32'h4001_4400, 32'h4001_3800, 32'h4001_3000,
    32'h4001_2c00, 32'h4001_2400, 32'h4001_0200, 32'h4001_0000, 32'h4000_7c00,
    32'h4000_7000, 32'h4000_5400, 32'h4000_4400, 32'h4000_3800, 32'h4000_3000,
    32'h4000_2c00, 32'h4000_2800, 32'h4000_2400, 32'h4000_2000, 32'h4000_0400};
  localparam logic [NUM_APB_WIN-1:0][31:0] APB_HI = {
    32'h4001_587f, 32'h4001_484c, 32'h4001_444c, 32'h4001_3818, 32'h4001_300c,
    32'h4001_2c4c, 32'h4001_2708, 32'h4001_021f, 32'h4001_01ff, 32'h4000_7c24,
    32'h4000_7014, 32'h4000_5430, 32'h4000_4418, 32'h4000_380c, 32'h4000_3010,
    32'h4000_2c08, 32'h4000_282c, 32'h4000_241c, 32'h4000_2050, 32'h4000_044c};
  localparam logic [NUM_APB_WIN-1:0][1:0] APB_CLS = {
    CLS_WORD, CLS_WORD, CLS_WORD, CLS_WORD, CLS_WORD,
    CLS_WORD, CLS_WORD, CLS_WORD, CLS_WORD, CLS_WORD,
    CLS_HALF, CLS_WORD, CLS_WORD, CLS_WORD, CLS_WORD,
    CLS_WORD, CLS_HALF, CLS_WORD, CLS_WORD, CLS_WORD};

  // boot latch on the fourth clock after reset release
  localparam int         BOOT_LATCH_CYC = 4;
  localparam logic [2:0] BOOT_CNT_LAST  = 3'(BOOT_LATCH_CYC - 1);

  // remap select encodings
  localparam logic [1:0] REMAP_FLASH  = 2'h0;
  localparam logic [1:0] REMAP_SYSMEM = 2'h1;
  localparam logic [1:0] REMAP_SRAM   = 2'h3;

  typedef enum logic [1:0] {BOOT_FLASH, BOOT_SYSMEM, BOOT_SRAM} sadb_boot_t;
  typedef enum logic [2:0] {TGT_FAULT, TGT_QUIET, TGT_SRAM, TGT_FLASH, TGT_AHBP,
                            TGT_APB} sadb_tgt_t;
  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_MEM, ST_APB_EN, ST_DONE} sadb_state_t;

endpackage

//--- sadb_properties.sv
`timescale 1ns/100ps
module sadb_properties (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        cpu_req,
  input wire logic        dma_req,
  input wire logic        cpu_gnt,
  input wire logic        dma_gnt,
  input wire logic [31:0] cpu_addr,
  input wire logic [1:0]  cpu_size,
  input wire logic        cpu_done,
  input wire logic        cpu_err,
  input wire logic        cpu_hard_fault,
  input wire logic [31:0] cpu_rdata,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        boot_done
);
  logic [2:0] cnt_r;
  logic       last_cpu_r;
  // saturating count keeps the check cheap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      last_cpu_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
      last_cpu_r <= cpu_gnt ? 1'b1 : (dma_gnt ? 1'b0 : last_cpu_r);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence apb_setup_s; psel && !penable; endsequence
  sequence apb_access_s; psel && penable; endsequence
  boot_latch_a: assert property (boot_done == (cnt_r >= 3'h4))
    else $error("boot done at wrong edge");
  no_early_gnt_a: assert property (!boot_done |-> !(cpu_gnt || dma_gnt))
    else $error("grant before boot latch");
  rr_cpu_a: assert property ((cpu_gnt && dma_req) |-> !last_cpu_r)
    else $error("cpu granted twice over dma");
  rr_dma_a: assert property ((dma_gnt && cpu_req) |-> last_cpu_r)
    else $error("dma granted twice over cpu");
  size_fault_a: assert property ((cpu_gnt && cpu_size == 2'h3) |=> cpu_done && cpu_err)
    else $error("bad size not faulted");
  fault_pulse_a: assert property (cpu_hard_fault |-> cpu_done && cpu_err ##1 !cpu_hard_fault)
    else $error("hard fault pulse wrong");
  apb_phase_a: assert property (apb_setup_s |=> apb_access_s)
    else $error("apb access phase missing");
  apb_quiet_a: assert property ((cpu_gnt && cpu_addr == 32'h4000_0000) |->
    ##[1:2] (cpu_done && !cpu_err && cpu_rdata == 32'h0)) else $error("apb hole not quiet");
endmodule
bind sadb_interconnect sadb_properties chk_u (.core_clk, .rst_n, .cpu_req, .dma_req,
  .cpu_gnt, .dma_gnt, .cpu_addr, .cpu_size, .cpu_done, .cpu_err, .cpu_hard_fault,
  .cpu_rdata, .psel, .penable, .boot_done);

//--- sadb_slave_model.sv
`timescale 1ns/100ps
module sadb_slave_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  stall,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_write,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        sram_req,
  input  wire logic        flash_req,
  input  wire logic        ahbp_req,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      rdata,
  output logic             sram_ack,
  output logic             flash_ack,
  output logic             ahbp_ack,
  output logic             pready
);
  logic [31:0] sram_m [0:2047];
  logic [31:0] apb_r;
  logic [31:0] val;
  logic [1:0]  cnt_r;
  logic        ack_r;
  logic        busy;
  assign busy = sram_req | flash_req | ahbp_req | (psel & penable);
  assign val = sram_req ? sram_m[mem_addr[12:2]] : flash_req ? ~mem_addr :
               ahbp_req ? {mem_addr[15:0], mem_addr[31:16]} : apb_r;
  // data outside the answer is inverted, never a stale copy
  assign rdata = ack_r ? val : ~val;
  assign sram_ack = ack_r & sram_req;
  assign flash_ack = ack_r & flash_req;
  assign ahbp_ack = ack_r & ahbp_req;
  assign pready = ack_r & psel & penable;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
      ack_r <= 1'b0;
      apb_r <= 32'h0;
    end else begin
      ack_r <= busy & ~ack_r & (cnt_r >= stall);
      cnt_r <= (busy & ~ack_r) ? cnt_r + 2'h1 : 2'h0;
      if (psel & penable & pwrite & ack_r) apb_r <= pwdata;
      for (int i = 0; i < 4; i++) begin
        if (sram_req & mem_write & ack_r & mem_be[i]) sram_m[mem_addr[12:2]][8*i+:8] <= mem_wdata[8*i+:8];
      end
    end
  end
endmodule

//--- sadb_win_match.sv
`timescale 1ns/100ps
module sadb_win_match #(
  parameter int NUM = 8
) (
  input  wire logic [31:0]           addr,
  input  wire logic [1:0]            size,
  input  wire logic [NUM-1:0][31:0]  win_lo,
  input  wire logic [NUM-1:0][31:0]  win_hi,
  input  wire logic [NUM-1:0][1:0]   win_cls,
  output logic                       hit,
  output logic                       size_ok
);

  logic [NUM-1:0] hit_v;
  logic [NUM-1:0] ok_v;

  genvar i;
  generate
    for (i = 0; i < NUM; i++) begin : g_win
      assign hit_v[i] = (addr >= win_lo[i]) && (addr <= win_hi[i]);
      // a window only takes the access widths it was built for
      assign ok_v[i]  = (size == sadb_pkg::SZ_WORD) ||
                        ((size == sadb_pkg::SZ_HALF) && (win_cls[i] != sadb_pkg::CLS_WORD)) ||
                        ((size == sadb_pkg::SZ_BYTE) && (win_cls[i] == sadb_pkg::CLS_ANY));
    end
  endgenerate

  assign hit     = |hit_v;
  assign size_ok = |(hit_v & ok_v);

endmodule
